// ==== verilog/rsc_top.sv ====
// Reset source control with Wishbone registers
`timescale 1ns/1ps
`include "rsc_params.svh"
module rsc_top
  import rsc_pkg::*;
#(
  parameter int POR_DELAY = `RSC_POR_DELAY_CYCLES,
  parameter int RAM_DEPTH = 16
)
(
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic rst_pin_n_i,
  input wire logic supply_ok_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic irq_o,
  output logic core_rst_o,
  output logic [15:0] pc_o,
  output logic [7:0] sp_o,
  output logic [7:0] port_o,
  output logic irq_enable_o,
  output logic timer_enable_o
);
  rsc_state_t state_reg;
  rsc_state_t state_next;
  rsc_cpu_state_t cpu_reg;
  logic [1:0] phase_reg;
  logic state_c4;
  logic ext_req;
  logic wdt_req;
  logic wdt_timeout;
  logic [7:0] watchdog_control_reg;
  logic [15:0] timeout_reg;
  logic [2:0] status_reg;
  logic [2:0] irq_en_reg;
  logic [1:0] cause_reg;
  logic [1:0] stretch_reg;
  logic wdt_hold_reg;
  logic [15:0] por_cnt_reg;
  logic por_busy_reg;
  logic por_done;
  logic [7:0] ram_mem [RAM_DEPTH];
  logic [3:0] ram_idx_reg;
  logic req_hit;
  logic wr_stb;
  logic rd_stb;
  logic wdt_clear;
  logic any_req;
  logic reset_active;
  logic [31:0] rd_data;
  logic [2:0] events;
  function automatic logic sel_is(input logic [7:0] adr, input logic [7:0] off);
    sel_is = (adr == off);
  endfunction
  // Machine cycle phase counter, state 3 is the fourth state
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      phase_reg <= 2'h0;
    end else begin
      phase_reg <= phase_reg + 2'h1;
    end
  end
  assign state_c4 = (phase_reg == `RSC_FOURTH_STATE); // [R1]
  rsc_pin_sampler u_sampler (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .state_c4_i(state_c4),
    .rst_pin_n_i(rst_pin_n_i),
    .ext_req_o(ext_req)
  );
  rsc_watchdog #(.CNT_W(16)) u_wdt (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i | reset_active),
    .run_i(watchdog_control_reg[`RSC_BIT_WDT_RUN]),
    .clear_i(wdt_clear),
    .reset_en_i(watchdog_control_reg[`RSC_BIT_RESET_EN]),
    .timeout_i(timeout_reg),
    .timeout_o(wdt_timeout),
    .wdt_req_o(wdt_req)
  );
  // Bus decode
  assign req_hit = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr_stb = req_hit & wb_we_i & wb_sel_i[0];
  assign rd_stb = req_hit & ~wb_we_i;
  assign wdt_clear = wr_stb & sel_is(wb_adr_i, 8'(`RSC_OFF_CONTROL)) & wb_dat_i[0];
  // Power-on delay after supply recovers
  assign por_done = por_busy_reg & (por_cnt_reg == 16'(POR_DELAY - 1));
  always_ff @(posedge ref_clk_i) begin
    if (rst_i | ~supply_ok_i) begin
      por_busy_reg <= 1'b1; // [R6]
      por_cnt_reg <= 16'h0000;
    end else if (por_busy_reg) begin
      por_cnt_reg <= por_cnt_reg + 16'h0001;
      if (por_done) begin
        por_busy_reg <= 1'b0;
      end
    end
  end
  assign any_req = ext_req | wdt_req | por_busy_reg; // [R19]
  // Reset sequencing: hold while requested, then stretch
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      RSC_RUN: begin
        if (any_req) begin
          state_next = RSC_HOLD; // [R3]
        end
      end
      RSC_HOLD: begin
        if (~any_req & ~wdt_hold_reg) begin
          state_next = RSC_STRETCH; // [R4]
        end
      end
      RSC_STRETCH: begin
        if (any_req) begin
          state_next = RSC_HOLD;
        end else if (stretch_reg == 2'(`RSC_STRETCH_CYCLES - 1) && state_c4) begin
          state_next = RSC_RUN;
        end
      end
      default: begin
        state_next = RSC_HOLD;
      end
    endcase
  end
  assign reset_active = (state_reg != RSC_RUN);
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      state_reg <= RSC_HOLD;
      stretch_reg <= 2'h0;
      wdt_hold_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      if (state_reg != RSC_STRETCH) begin
        stretch_reg <= 2'h0;
      end else if (state_c4) begin
        stretch_reg <= stretch_reg + 2'h1;
      end
      // Watchdog reset held until the next fourth clock state by hardware
      if (wdt_req) begin
        wdt_hold_reg <= 1'b1; // [R10]
      end else if (state_c4) begin
        wdt_hold_reg <= 1'b0;
      end
    end
  end
  // Core state forced while reset is applied
  always_ff @(posedge ref_clk_i) begin
    if (rst_i | reset_active) begin
      cpu_reg.pc <= `RSC_PC_RESET; // [R11]
      cpu_reg.sp <= `RSC_SP_RESET; // [R11]
      cpu_reg.port <= `RSC_PORT_RESET; // [R13]
      cpu_reg.irq_en <= 1'b0; // [R13]
      cpu_reg.timer_en <= 1'b0; // [R13]
    end else begin
      cpu_reg.pc <= cpu_reg.pc + 16'h0001;
    end
  end
  // Control register with cause-dependent reset
  always_ff @(posedge ref_clk_i) begin
    if (rst_i | por_busy_reg) begin
      watchdog_control_reg <= 8'h00; // [R17]
      watchdog_control_reg[`RSC_BIT_POR] <= 1'b1; // [R15]
      cause_reg <= 2'h0;
    end else if (wdt_req) begin
      watchdog_control_reg[`RSC_BIT_CAUSE] <= 1'b1; // [R16]
      watchdog_control_reg[`RSC_BIT_WDT_RUN] <= 1'b1; // [R14]
      watchdog_control_reg[`RSC_BIT_TIMEOUT] <= 1'b0; // [R15]
      cause_reg <= 2'h2;
    end else if (ext_req) begin
      cause_reg <= 2'h1; // [R5]
    end else begin
      if (wr_stb & sel_is(wb_adr_i, 8'(`RSC_OFF_CONTROL))) begin
        watchdog_control_reg[7:1] <= wb_dat_i[7:1];
      end
      if (wdt_timeout) begin
        watchdog_control_reg[`RSC_BIT_TIMEOUT] <= 1'b1; // [R18]
      end
    end
  end
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      timeout_reg <= `RSC_WDT_TIMEOUT_RESET;
    end else if (wr_stb & sel_is(wb_adr_i, 8'(`RSC_OFF_TIMEOUT))) begin
      timeout_reg <= wb_dat_i[15:0];
    end
  end
  // Sticky events; set wins over clear
  assign events = {ext_req, wdt_req, wdt_timeout};
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      status_reg <= 3'h0;
      irq_en_reg <= 3'h0;
    end else begin
      if (wr_stb & sel_is(wb_adr_i, 8'(`RSC_OFF_IRQ_CLR))) begin
        status_reg <= (status_reg & ~wb_dat_i[2:0]) | events;
      end else begin
        status_reg <= status_reg | events;
      end
      if (wr_stb & sel_is(wb_adr_i, 8'(`RSC_OFF_IRQ_EN))) begin
        irq_en_reg <= wb_dat_i[2:0];
      end
    end
  end
  // Scratch RAM not touched by reset
  always_ff @(posedge ref_clk_i) begin
    if (wr_stb & (wb_adr_i[7:6] == 2'h1)) begin
      ram_mem[wb_adr_i[5:2]] <= wb_dat_i[7:0]; // [R12]
    end
    if (rst_i) begin
      ram_idx_reg <= 4'h0;
    end else if (rd_stb) begin
      ram_idx_reg <= wb_adr_i[5:2];
    end
  end
  assign rd_data =
    sel_is(wb_adr_i, 8'(`RSC_OFF_CONTROL)) ? {24'h00_0000, watchdog_control_reg} :
    sel_is(wb_adr_i, 8'(`RSC_OFF_TIMEOUT)) ? {16'h0000, timeout_reg} :
    sel_is(wb_adr_i, 8'(`RSC_OFF_STATUS)) ? {29'h0000_0000, status_reg} :
    sel_is(wb_adr_i, 8'(`RSC_OFF_IRQ_EN)) ? {29'h0000_0000, irq_en_reg} :
    sel_is(wb_adr_i, 8'(`RSC_OFF_CAUSE)) ? {30'h0000_0000, cause_reg} :
    32'h0000_0000;
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= req_hit;
      if (rd_stb) begin
        wb_dat_o <= (wb_adr_i[7:6] == 2'h1) ? {24'h00_0000, ram_mem[wb_adr_i[5:2]]} : rd_data;
      end
    end
  end
  assign irq_o = |(status_reg & irq_en_reg);
  assign core_rst_o = reset_active; // [R3]
  assign pc_o = cpu_reg.pc;
  assign sp_o = cpu_reg.sp;
  assign port_o = cpu_reg.port;
  assign irq_enable_o = cpu_reg.irq_en;
  assign timer_enable_o = cpu_reg.timer_en;
endmodule

// ==== verilog/rsc_params.svh ====
// Constants for the reset source control block
// Notes on behaviour
// (R1) Sample reset pin at fourth clock state
// (R2) Board holds pin low two machine cycles
// (R3) Internal reset applied synchronously to clock
// (R4) Hold reset while low, plus two cycles
// (R5) External reset sets no cause flag
// (R6) Supply low resets; delay then set flag
// (R7) Software clears power-on flag after reading
// (R8) Watchdog free runs, clearable, sets timeout flag
// (R9) Watchdog reset 512 clocks after flag
// (R10) Watchdog reset held two machine cycles
// (R11) Program counter 0000h, stack pointer 07h
// (R12) Reset leaves data RAM unchanged
// (R13) Ports all ones; enables, timers cleared
// (R14) Watchdog disabled only after power-on reset
// (R15) Control reset value depends on cause
// (R16) Cause bit set by watchdog, cleared power-on
// (R17) Reset enable cleared only by power-on
// (R18) Timeout sets flag bit 3
// (R19) Internal reset ORs all stretched requests
`ifndef RSC_PARAMS_SVH
`define RSC_PARAMS_SVH
`define RSC_STATES_PER_CYCLE 4
`define RSC_FOURTH_STATE 2'h3
`define RSC_STRETCH_CYCLES 2
`define RSC_WDT_RESET_DELAY 512
`define RSC_POR_DELAY_CYCLES 16
`define RSC_PC_RESET 16'h0000
`define RSC_SP_RESET 8'h07
`define RSC_PORT_RESET 8'hff
`define RSC_OFF_CONTROL 8'h00
`define RSC_OFF_TIMEOUT 8'h04
`define RSC_OFF_STATUS 8'h08
`define RSC_OFF_IRQ_CLR 8'h0c
`define RSC_OFF_IRQ_EN 8'h10
`define RSC_OFF_CAUSE 8'h14
`define RSC_OFF_RAM 8'h18
`define RSC_BIT_RESET_EN 1
`define RSC_BIT_CAUSE 2
`define RSC_BIT_TIMEOUT 3
`define RSC_BIT_POR 6
`define RSC_BIT_WDT_RUN 7
`define RSC_WDT_TIMEOUT_RESET 16'h0400
`endif

// ==== verilog/rsc_pkg.sv ====
// Types for the reset source control block
package rsc_pkg;
  typedef struct packed {
    logic [15:0] pc;
    logic [7:0] sp;
    logic [7:0] port;
    logic irq_en;
    logic timer_en;
  } rsc_cpu_state_t;
  typedef enum logic [1:0] {
    RSC_RUN = 2'b00,
    RSC_HOLD = 2'b01,
    RSC_STRETCH = 2'b10
  } rsc_state_t;
endpackage

// ==== verilog/rsc_pin_sampler.sv ====
// Reset pin sampler at the fourth clock state
`timescale 1ns/1ps
`include "rsc_params.svh"
module rsc_pin_sampler
  import rsc_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic state_c4_i,
  input wire logic rst_pin_n_i,
  output logic ext_req_o
);
  logic [1:0] low_cnt_reg;
  logic [1:0] low_cnt_next;
  logic sampled_low;
  assign sampled_low = state_c4_i & ~rst_pin_n_i; // [R1]
  assign low_cnt_next = sampled_low ? ((low_cnt_reg == 2'h2) ? 2'h2 : low_cnt_reg + 2'h1) :
                        (state_c4_i ? 2'h0 : low_cnt_reg);
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      low_cnt_reg <= 2'h0;
    end else begin
      low_cnt_reg <= low_cnt_next;
    end
  end
  // Two low samples make a valid request
  assign ext_req_o = (low_cnt_reg == 2'h2); // [R2]
endmodule

// ==== verilog/rsc_watchdog.sv ====
// Free running watchdog counter
`timescale 1ns/1ps
`include "rsc_params.svh"
module rsc_watchdog
  import rsc_pkg::*;
#(
  parameter int CNT_W = 16
)
(
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic run_i,
  input wire logic clear_i,
  input wire logic reset_en_i,
  input wire logic [CNT_W-1:0] timeout_i,
  output logic timeout_o,
  output logic wdt_req_o
);
  localparam logic [9:0] DELAY = 10'(`RSC_WDT_RESET_DELAY - 1);
  logic [CNT_W-1:0] cnt_reg;
  logic [9:0] dly_reg;
  logic armed_reg;
  logic hit;
  assign hit = run_i & (cnt_reg == timeout_i);
  assign timeout_o = hit; // [R8]
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      cnt_reg <= '0;
      dly_reg <= 10'h000;
      armed_reg <= 1'b0;
      wdt_req_o <= 1'b0;
    end else begin
      wdt_req_o <= 1'b0;
      if (clear_i) begin
        cnt_reg <= '0; // [R8]
        armed_reg <= 1'b0;
        dly_reg <= 10'h000;
      end else begin
        if (run_i) begin
          cnt_reg <= hit ? '0 : cnt_reg + 1'b1;
        end
        if (hit & ~armed_reg) begin
          armed_reg <= 1'b1;
          dly_reg <= 10'h000;
        end else if (armed_reg) begin
          dly_reg <= dly_reg + 10'h001;
          if (dly_reg == DELAY) begin
            armed_reg <= 1'b0;
            wdt_req_o <= reset_en_i; // [R9]
          end
        end
      end
    end
  end
endmodule

// ==== testbench/rsc_top_sva.sv ====
// Port checker for reset source control
`timescale 1ns/1ps
module rsc_top_sva (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic rst_pin_n_i,
  input wire logic supply_ok_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic core_rst_o,
  input wire logic [15:0] pc_o,
  input wire logic [7:0] sp_o,
  input wire logic [7:0] port_o,
  input wire logic irq_enable_o,
  input wire logic timer_enable_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_held;
    core_rst_o && $past(core_rst_o);
  endsequence
  a_ack_next: assert property (s_req |=> wb_ack_o)
    else $error("no ack after request");
  a_unmapped_zero: assert property (s_req and (!wb_we_i && wb_adr_i == 8'h20) |=>
    wb_dat_o == 32'h0000_0000) else $error("unmapped read not zero");
  a_pc_sp_init: assert property (s_held |-> pc_o == 16'h0000 && sp_o == 8'h07)
    else $error("pc or sp wrong in reset");
  a_port_ones: assert property (s_held |-> port_o == 8'hff && !irq_enable_o && !timer_enable_o)
    else $error("port or enables wrong in reset");
  a_pin_low_resets: assert property (!rst_pin_n_i [*8] |-> ##[0:8] core_rst_o)
    else $error("pin low gave no reset");
  a_hold_while_low: assert property (core_rst_o && !rst_pin_n_i |=> core_rst_o)
    else $error("reset left while pin low");
  a_reset_held: assert property ($rose(core_rst_o) |-> core_rst_o [*8])
    else $error("reset shorter than two machine cycles");
  a_supply_low: assert property (!supply_ok_i |-> ##[0:4] core_rst_o)
    else $error("supply low gave no reset");
  a_por_delay: assert property ($rose(supply_ok_i) |-> core_rst_o [*8])
    else $error("power-on delay too short");
endmodule
bind rsc_top rsc_top_sva u_sva (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
  .rst_pin_n_i(rst_pin_n_i), .supply_ok_i(supply_ok_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .core_rst_o(core_rst_o), .pc_o(pc_o), .sp_o(sp_o),
  .port_o(port_o), .irq_enable_o(irq_enable_o), .timer_enable_o(timer_enable_o));

// ==== testbench/rsc_rst_source.sv ====
// Board reset source driving the reset pin
`timescale 1ns/1ps
module rsc_rst_source (
  input wire logic ref_clk_i,
  input wire logic go_i,
  input wire logic [7:0] low_len_i,
  output logic rst_pin_n_o
);
  logic [7:0] left_reg = 8'h00;
  always_ff @(posedge ref_clk_i) begin
    if (go_i) begin
      left_reg <= low_len_i;
    end else if (left_reg != 8'h00) begin
      left_reg <= left_reg - 8'h01;
    end
  end
  // Low for the commanded clocks, pulled up after
  assign rst_pin_n_o = (left_reg == 8'h00);
endmodule

// ==== testbench/test_rsc_top.sv ====
// Self-checking bench for reset source control
`timescale 1ns/1ps
module test_rsc_top;
  logic ref_clk_i;
  logic rst_i = 1'b1;
  logic supply_ok_i = 1'b1;
  logic cyc = 1'b0;
  logic we = 1'b0;
  logic go = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [7:0] len = 8'h00;
  logic [31:0] wdat = 32'h0000_0000;
  logic [31:0] dat_o;
  logic [31:0] rdat;
  logic ack;
  logic irq;
  logic core_rst;
  logic pin_n;
  int error_cnt = 0;
  int checks_done = 0;
  rsc_rst_source board (.ref_clk_i(ref_clk_i), .go_i(go), .low_len_i(len), .rst_pin_n_o(pin_n));
  rsc_top #(.POR_DELAY(4)) uut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .rst_pin_n_i(pin_n),
    .supply_ok_i(supply_ok_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack), .irq_o(irq),
    .core_rst_o(core_rst), .pc_o(), .sp_o(), .port_o(), .irq_enable_o(), .timer_enable_o());
  initial begin
    ref_clk_i = 1'b0;
    forever #50 ref_clk_i = ~ref_clk_i;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk_i);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge ref_clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    rdat = dat_o;
    cyc <= 1'b0;
    if (n >= 20) error_cnt++;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0000_0000);
    chk(rdat, exp);
  endtask
  task automatic wait_rst(input logic lvl);
    for (int i = 0; i < 2000 && core_rst !== lvl; i++) @(posedge ref_clk_i);
    chk(core_rst, lvl);
  endtask
  task automatic pulse_pin(input logic [7:0] n);
    @(posedge ref_clk_i);
    len <= n;
    go <= 1'b1;
    @(posedge ref_clk_i);
    go <= 1'b0;
  endtask
  task automatic t_por;
    wait_rst(1'b0);
    rd(8'h00, 32'h0000_0040);
    rd(8'h14, 32'h0000_0000);
    rd(8'h20, 32'h0000_0000);
    wb(1'b1, 8'h40, 32'h0000_00a5);
    wb(1'b1, 8'h00, 32'h0000_0000);
    $display("power-on test done");
  endtask
  task automatic t_ext;
    logic [31:0] ctl;
    wb(1'b0, 8'h00, 32'h0000_0000);
    ctl = rdat;
    pulse_pin(8'h0c);
    wait_rst(1'b1);
    wait_rst(1'b0);
    rd(8'h00, ctl);
    rd(8'h14, 32'h0000_0001);
    rd(8'h40, 32'h0000_00a5);
    $display("external reset test done");
  endtask
  task automatic t_glitch;
    pulse_pin(8'h02);
    repeat (16) begin
      @(posedge ref_clk_i);
      chk(core_rst, 1'b0);
    end
    $display("short pulse test done");
  endtask
  task automatic t_wdt;
    time t0;
    wb(1'b1, 8'h04, 32'h0000_0010);
    wb(1'b1, 8'h10, 32'h0000_0001);
    repeat (10) wb(1'b1, 8'h00, 32'h0000_0083);
    chk(irq, 1'b0);
    for (int i = 0; i < 100 && irq !== 1'b1; i++) @(posedge ref_clk_i);
    t0 = $time;
    wb(1'b1, 8'h10, 32'h0000_0000);
    chk(irq, 1'b0);
    wb(1'b1, 8'h10, 32'h0000_0001);
    chk(irq, 1'b1);
    rd(8'h00, 32'h0000_008a);
    chk(rdat & 32'h0000_0008, 32'h0000_0008);
    wb(1'b1, 8'h0c, 32'h0000_0001);
    chk(irq, 1'b0);
    wait_rst(1'b1);
    chk(32'(($time - t0) / 100 >= 510 && ($time - t0) / 100 <= 514), 32'h0000_0001);
    wait_rst(1'b0);
    rd(8'h14, 32'h0000_0002);
    wb(1'b0, 8'h00, 32'h0000_0000);
    chk(rdat & 32'h0000_0006, 32'h0000_0006);
    wb(1'b1, 8'h10, 32'h0000_0000);
    wb(1'b1, 8'h00, 32'h0000_0003);
    $display("watchdog test done");
  endtask
  task automatic t_supply;
    @(posedge ref_clk_i);
    supply_ok_i <= 1'b0;
    repeat (6) @(posedge ref_clk_i);
    supply_ok_i <= 1'b1;
    wait_rst(1'b0);
    rd(8'h00, 32'h0000_0040);
    $display("supply test done");
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    t_por();
    t_ext();
    t_glitch();
    t_wdt();
    t_supply();
    give_verdict();
  end
  initial begin
    #1000000;
    error_cnt++;
    give_verdict();
  end
endmodule
